//--- include/cfg_port_pkg.sv
// Purpose: shared constants and types of the configuration serial port
// Assumes: system clock of 125 MHz drives every block of the port
// Notes: bus addresses are 8-bit values with the direction bit in bit 0
package cfg_port_pkg;

    // system clock period in ns
    localparam int SYS_CLK_NS = 8;
    // target address after configuration load, and the alternate one
    localparam logic [7:0] ADDR_DEFAULT = 8'hd4;
    localparam logic [7:0] ADDR_ALTERNATE = 8'hd0;
    // data hold time the port keeps after the serial clock falls
    localparam int T_HOLD_NS = 300;
    // least time rounds up to whole cycles
    localparam int HOLD_CYC_INT = (T_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [5:0] HOLD_CYC = HOLD_CYC_INT[5:0];
    // register position width and staging buffer depth
    localparam int REG_AW = 8;
    localparam int STAGE_DEPTH = 8;
    // bit count that marks a whole byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] SHIFT_RST = 8'h00;

    // link sequencing states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_MACK,
        ST_RLOAD
    } link_state_t;

endpackage : cfg_port_pkg

//--- verilog/pin_sync.sv
// Purpose: bring the serial clock and data pins into the system clock
// Assumes: pins are asynchronous to sys_clk
// Notes: edge, start and stop detection look only at synchronised copies
`timescale 1ns/10ps
`default_nettype none
module pin_sync
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_s,
    output logic sda_s,
    output logic scl_rise,
    output logic scl_fall,
    output logic bus_start,
    output logic bus_stop
);
    // first stage, read only by the second stage
    logic [1:0] meta_ff;
    // second stage and previous sample
    logic [1:0] sync_ff;
    logic [1:0] prev_ff;
    logic [1:0] nxt_meta;
    logic [1:0] nxt_sync;
    logic [1:0] nxt_prev;

    // next values of the synchroniser chain
    always_comb
    begin
        nxt_meta = {scl_in, sda_in};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // register the chain; idle bus reads high
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
            prev_ff <= 2'h3;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign scl_s = sync_ff[1];
    assign sda_s = sync_ff[0];
    assign scl_rise = sync_ff[1] & ~prev_ff[1];
    assign scl_fall = ~sync_ff[1] & prev_ff[1];
    // data edges while the clock stays high frame a transfer
    assign bus_start = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
    assign bus_stop = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];

endmodule : pin_sync
`default_nettype wire

//--- verilog/stage_fifo.sv
// Purpose: staging buffer for write bytes awaiting the stop condition
// Assumes: single clock, valid/ready on both sides
// Notes: full and empty come from pointers with one extra wrap bit
`timescale 1ns/10ps
`default_nettype none
module stage_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    // storage array, written only on an accepted push
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr_ff;
    logic [PW:0] rd_ptr_ff;
    logic [PW:0] nxt_wr_ptr;
    logic [PW:0] nxt_rd_ptr;
    logic push;
    logic pop;

    // full when indices match and wrap bits differ
    always_comb
    begin
        in_ready = !((wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]) &&
                     (wr_ptr_ff[PW] != rd_ptr_ff[PW]));
        out_valid = (wr_ptr_ff != rd_ptr_ff);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        out_data = mem[rd_ptr_ff[PW-1:0]];
    end

    // pointers reset to empty
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // array needs no reset; only pushed words are ever read
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_ff[PW-1:0]] <= in_data;
        end
    end

endmodule : stage_fifo
`default_nettype wire

//--- verilog/cfg_i2c_target.sv
// Purpose: two-wire bus target giving block access to configuration registers
// Assumes: register file answers rd_data for rd_addr in the same clock
// Notes: write bytes are staged and handed over only after stop
`timescale 1ns/10ps
`default_nettype none

module cfg_i2c_target
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic cfg_loaded,
    input wire logic addr_sel_lower,
    output logic [cfg_port_pkg::REG_AW-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [cfg_port_pkg::REG_AW-1:0] wr_addr,
    output logic [7:0] wr_data,
    output logic cfg_commit
);
    import cfg_port_pkg::*;

    // synchronised pins and bus events; the clock level itself is never read
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // link sequencing state
    link_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, nxt_shift;          // byte being moved
    logic [3:0] cnt_ff, nxt_cnt;              // bits moved in this byte
    logic [REG_AW-1:0] ptr_ff, nxt_ptr;       // current register position
    logic rw_ff, nxt_rw;                      // direction bit of last address
    logic want_oe_ff, nxt_want;               // pull level to apply after hold
    logic [5:0] hold_ff, nxt_hold;            // cycles left before data changes
    logic oe_ff, nxt_oe;                      // driven pull enable
    logic wrote_ff, nxt_wrote;                // staged bytes in this transfer
    logic push_valid;                         // one staged byte this cycle
    logic stop_commit;                        // stop closes a write block
    logic [7:0] own_addr;

    // staging buffer ports
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [REG_AW+7:0] fifo_out_data;
    logic pop;

    // hand-over group state
    logic pending_ff, nxt_pending;
    logic wr_valid_ff, nxt_wr_valid;
    logic [REG_AW-1:0] wr_addr_ff, nxt_wr_addr;
    logic [7:0] wr_data_ff, nxt_wr_data;
    logic commit_ff, nxt_commit;

    pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .bus_start(bus_start),
        .bus_stop(bus_stop)
    );

    // the selected address follows the configuration bit
    assign own_addr = addr_sel_lower ? ADDR_ALTERNATE : ADDR_DEFAULT;

    // link sequencer: bits move on synchronised clock edges
    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_want = want_oe_ff;
        nxt_hold = hold_ff;
        nxt_oe = oe_ff;
        nxt_wrote = wrote_ff;
        push_valid = 1'b0;
        stop_commit = 1'b0;
        // data changes only after the hold time past the falling clock
        if (hold_ff != 6'h00)
        begin
            nxt_hold = hold_ff - 6'h01;
            if (hold_ff == 6'h01)
            begin
                nxt_oe = want_oe_ff;
            end
        end
        if (!cfg_loaded)
        begin
            // nothing on the bus is seen before configuration is in
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
            nxt_want = 1'b0;
            nxt_hold = 6'h00;
            nxt_wrote = 1'b0;
        end
        else if (bus_stop)
        begin
            // stop releases the line and closes any write block
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
            nxt_want = 1'b0;
            nxt_hold = 6'h00;
            stop_commit = wrote_ff;
            nxt_wrote = 1'b0;
        end
        else if (bus_start)
        begin
            // start or repeated start always begins an address byte
            nxt_state = ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_want = 1'b0;
            nxt_hold = 6'h00;
        end
        else
        begin
            case (state_ff)
                ST_ADDR, ST_REG, ST_WDATA:
                begin
                    // receive most significant bit first
                    if (scl_rise && cnt_ff != BYTE_BITS)
                    begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (scl_fall && cnt_ff == BYTE_BITS)
                    begin
                        nxt_hold = HOLD_CYC;
                        if (state_ff == ST_ADDR)
                        begin
                            // busy staging counts as not present
                            if (shift_ff[7:1] == own_addr[7:1] && !pending_ff)
                            begin
                                nxt_want = 1'b1;
                                nxt_rw = shift_ff[0];
                                nxt_state = ST_ADDR_ACK;
                            end
                            else
                            begin
                                nxt_state = ST_IDLE;
                            end
                        end
                        else if (state_ff == ST_REG)
                        begin
                            nxt_ptr = shift_ff;
                            nxt_want = 1'b1;
                            nxt_state = ST_REG_ACK;
                        end
                        else if (fifo_in_ready)
                        begin
                            // stage the byte with its position
                            push_valid = 1'b1;
                            nxt_ptr = ptr_ff + 1'b1;
                            nxt_wrote = 1'b1;
                            nxt_want = 1'b1;
                            nxt_state = ST_WDATA_ACK;
                        end
                        else
                        begin
                            // buffer full: refuse the byte
                            nxt_state = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_hold = HOLD_CYC;
                        nxt_cnt = 4'h0;
                        if (rw_ff)
                        begin
                            // read begins at the current position
                            nxt_shift = rd_data;
                            nxt_want = ~rd_data[7];
                            nxt_state = ST_RDATA;
                        end
                        else
                        begin
                            nxt_want = 1'b0;
                            nxt_state = ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_hold = HOLD_CYC;
                        nxt_want = 1'b0;
                        nxt_cnt = 4'h0;
                        nxt_state = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    // the controller samples each bit on the rising clock
                    if (scl_rise)
                    begin
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        nxt_hold = HOLD_CYC;
                        if (cnt_ff == BYTE_BITS)
                        begin
                            // release for the controller's answer
                            nxt_want = 1'b0;
                            nxt_ptr = ptr_ff + 1'b1;
                            nxt_state = ST_MACK;
                        end
                        else
                        begin
                            nxt_want = ~shift_ff[7];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        // a missing acknowledge ends the read
                        nxt_state = sda_s ? ST_IDLE : ST_RLOAD;
                    end
                end
                ST_RLOAD:
                begin
                    if (scl_fall)
                    begin
                        nxt_hold = HOLD_CYC;
                        nxt_shift = rd_data;
                        nxt_want = ~rd_data[7];
                        nxt_cnt = 4'h0;
                        nxt_state = ST_RDATA;
                    end
                end
                default:
                begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // register the link sequencer
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            shift_ff <= SHIFT_RST;
            cnt_ff <= 4'h0;
            ptr_ff <= PTR_RST;
            rw_ff <= 1'b0;
            want_oe_ff <= 1'b0;
            hold_ff <= 6'h00;
            oe_ff <= 1'b0;
            wrote_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            want_oe_ff <= nxt_want;
            hold_ff <= nxt_hold;
            oe_ff <= nxt_oe;
            wrote_ff <= nxt_wrote;
        end
    end

    // staging buffer: refuses bytes when full, drained after stop
    stage_fifo
    #(
        .WIDTH(REG_AW + 8),
        .DEPTH(STAGE_DEPTH)
    )
    u_stage
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data({ptr_ff, shift_ff}),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // hand-over: drain staged bytes, then one commit pulse
    always_comb
    begin
        nxt_pending = pending_ff;
        nxt_wr_valid = wr_valid_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        nxt_commit = 1'b0;
        pop = pending_ff && fifo_out_valid && (!wr_valid_ff || wr_ready);
        if (wr_valid_ff && wr_ready)
        begin
            nxt_wr_valid = 1'b0;
        end
        if (pop)
        begin
            nxt_wr_valid = 1'b1;
            nxt_wr_addr = fifo_out_data[REG_AW+7:8];
            nxt_wr_data = fifo_out_data[7:0];
        end
        else if (pending_ff && !fifo_out_valid && (!wr_valid_ff || wr_ready))
        begin
            // the register file applies its shadow copy all at once
            nxt_commit = 1'b1;
            nxt_pending = 1'b0;
        end
        // a new stop wins over the clear
        if (stop_commit)
        begin
            nxt_pending = 1'b1;
        end
    end

    // register the hand-over group
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_ff <= 1'b0;
            wr_valid_ff <= 1'b0;
            wr_addr_ff <= PTR_RST;
            wr_data_ff <= SHIFT_RST;
            commit_ff <= 1'b0;
        end
        else
        begin
            pending_ff <= nxt_pending;
            wr_valid_ff <= nxt_wr_valid;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
            commit_ff <= nxt_commit;
        end
    end

    // open-drain: the data line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = oe_ff;
    assign rd_addr = ptr_ff;
    assign wr_valid = wr_valid_ff;
    assign wr_addr = wr_addr_ff;
    assign wr_data = wr_data_ff;
    assign cfg_commit = commit_ff;

endmodule : cfg_i2c_target
`default_nettype wire

//--- dv/cfg_i2c_target_chk.sv
// Purpose: concurrent checks on the configuration port pins
// Assumes: data pin is open drain with a pull-up
// Notes: bound to every cfg_i2c_target instance
`timescale 1ns/10ps
`default_nettype none
module cfg_i2c_target_chk
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic cfg_loaded,
    input wire logic addr_sel_lower,
    input wire logic [cfg_port_pkg::REG_AW-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [cfg_port_pkg::REG_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic cfg_commit
);
    import cfg_port_pkg::*;
    logic [REG_AW-1:0] last_ff, nxt_last; // position of the previous handover
    // remember each handed-over position so the next one can be tied to it
    always_comb
    begin
        nxt_last = last_ff;
        if (wr_valid && wr_ready)
        begin
            nxt_last = wr_addr;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            last_ff <= 8'h00;
        end
        else
        begin
            last_ff <= nxt_last;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_handover;
        wr_valid && wr_ready;
    endsequence
    sequence s_pulse;
        cfg_commit ##1 !cfg_commit;
    endsequence
    property p_wr_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request not held");
    property p_commit_pulse;
        cfg_commit |-> s_pulse;
    endproperty
    a_commit_pulse: assert property (p_commit_pulse) else $error("commit not one cycle");
    property p_commit_idle;
        cfg_commit |-> scl_in && sda_in && !wr_valid;
    endproperty
    a_commit_idle: assert property (p_commit_idle) else $error("commit before stop");
    property p_handover_idle;
        $rose(wr_valid) |-> scl_in && sda_in;
    endproperty
    a_handover_idle: assert property (p_handover_idle) else $error("write before stop");
    property p_handover_next;
        s_handover |=> ##[0:8] (wr_valid || cfg_commit);
    endproperty
    a_handover_next: assert property (p_handover_next) else $error("block stalled");
    property p_wr_ascend;
        s_handover ##1 wr_valid |-> wr_addr == last_ff + 8'h01;
    endproperty
    a_wr_ascend: assert property (p_wr_ascend) else $error("write position skipped");
    property p_rd_move;
        $changed(rd_addr) |-> !scl_in;
    endproperty
    a_rd_move: assert property (p_rd_move) else $error("position moved in clock high");
    property p_oe_rise;
        $rose(sda_oe) |-> !scl_in && !sda_out;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("data driven in clock high");
    property p_oe_fall;
        $fell(sda_oe) |-> !scl_in;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("data released in clock high");
    property p_quiet;
        !cfg_loaded && !sda_oe |=> !sda_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer before load");
endmodule : cfg_i2c_target_chk
bind cfg_i2c_target cfg_i2c_target_chk chk (.sys_clk(sys_clk), .resetn(resetn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .cfg_loaded(cfg_loaded), .addr_sel_lower(addr_sel_lower), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .cfg_commit(cfg_commit));
`default_nettype wire

//--- dv/i2c_ctrl_model.sv
// Purpose: behavioural bus controller driving the port's pins
// Assumes: pull-up on both lines, so a released line reads high
// Notes: clock low phase is long enough for the port's hold delay
`timescale 1ns/10ps
`default_nettype none
module i2c_ctrl_model
#(
    parameter int T_LOW = 1800, // with the high phase, a 400 kHz bus clock
    parameter int T_HIGH = 700
)
(
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic drv_low; // controller pulls the data line
    // wired and of both parties with the pull-up
    assign sda = !(drv_low || sda_oe);
    initial
    begin
        scl = 1'b1;
        drv_low = 1'b0;
    end
    // start or repeated start: both lines rise before data falls
    task automatic bus_start();
        drv_low = 1'b0;
        #(T_LOW);
        scl = 1'b1;
        #600;
        drv_low = 1'b1;
        #600;
        scl = 1'b0;
    endtask : bus_start
    // one clock pulse; data changes well after the fall, sampled mid high
    task automatic clock_bit(input logic val, output logic seen);
        #100;
        drv_low = !val;
        #(T_LOW - 100);
        scl = 1'b1;
        #(T_HIGH / 2);
        seen = sda;
        #(T_HIGH / 2);
        scl = 1'b0;
    endtask : clock_bit
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s); // most significant bit first
        clock_bit(1'b1, s);
        ack = !s;
    endtask : put_byte
    // last byte of a read is left unacknowledged by the caller
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, b[i]);
        clock_bit(!ack, s);
    endtask : get_byte
    // stop then a long idle so the staged bytes can drain
    task automatic bus_stop();
        #100;
        drv_low = 1'b1;
        #(T_LOW - 100);
        scl = 1'b1;
        #600;
        drv_low = 1'b0;
        #2000;
    endtask : bus_stop
endmodule : i2c_ctrl_model
`default_nettype wire

//--- dv/cfg_i2c_target_bench.sv
// Purpose: self-checking bench of the configuration port
// Assumes: register file modelled here, applied on commit
// Notes: write ready toggles every cycle to stall the handover
`timescale 1ns/10ps
`default_nettype none
module cfg_i2c_target_bench;
    import cfg_port_pkg::*;
    logic sys_clk, resetn, scl_in, sda_in, sda_out, sda_oe, cfg_loaded, addr_sel_lower;
    logic [REG_AW-1:0] rd_addr, wr_addr;
    logic [7:0] rd_data, wr_data;
    logic [7:0] regs [256];
    logic [7:0] shadow [256];
    logic pend [256];
    logic wr_valid, wr_ready, cfg_commit;
    int errors, n_compared, n_commit, cycles;
    assign rd_data = regs[rd_addr]; // register file reads in the same cycle
    cfg_i2c_target dut (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_loaded(cfg_loaded),
        .addr_sel_lower(addr_sel_lower), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .cfg_commit(cfg_commit));
    i2c_ctrl_model ctrl (.sda_oe(sda_oe), .scl(scl_in), .sda(sda_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // bench-only initial register contents
    function automatic logic [7:0] init_val(input int i);
        return 8'(i) ^ 8'h3c;
    endfunction : init_val
    // register file: writes shadowed, applied together at commit; also the hang limit
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        wr_ready <= #1 !wr_ready;
        if (wr_valid && wr_ready)
        begin
            shadow[wr_addr] <= wr_data;
            pend[wr_addr] <= 1'b1;
        end
        if (cfg_commit)
        begin
            n_commit <= n_commit + 1;
            for (int i = 0; i < 256; i++)
            begin
                regs[i] <= pend[i] ? shadow[i] : regs[i];
                pend[i] <= 1'b0;
            end
        end
        if (cycles == 80000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one byte from the controller and its expected acknowledge
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        ctrl.put_byte(b, a);
        check({7'h00, a}, {7'h00, exp_ack});
    endtask : send
    task automatic test_unloaded();
        ctrl.bus_start();
        send(ADDR_DEFAULT, 1'b0);
        ctrl.bus_stop();
        @(posedge sys_clk);
        #1 cfg_loaded = 1'b1;
        $display("test_unloaded done");
    endtask : test_unloaded
    task automatic test_write();
        int c0;
        c0 = n_commit;
        ctrl.bus_start();
        send(ADDR_DEFAULT, 1'b1);
        send(8'h10, 1'b1);
        for (int i = 0; i < 3; i++)
            send(8'h96 + 8'(i), 1'b1);
        check(regs[8'h10], init_val(8'h10));
        ctrl.bus_stop();
        check(8'(n_commit - c0), 8'h01);
        for (int i = 0; i < 3; i++)
            check(regs[8'h10 + i], 8'h96 + 8'(i));
        $display("test_write done");
    endtask : test_write
    task automatic test_seq_read();
        logic [7:0] d;
        ctrl.bus_start();
        send(ADDR_DEFAULT, 1'b1);
        send(8'h10, 1'b1);
        ctrl.bus_start();
        send(ADDR_DEFAULT | 8'h01, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            ctrl.get_byte(i < 2, d);
            check(d, 8'h96 + 8'(i));
        end
        ctrl.bus_stop();
        $display("test_seq_read done");
    endtask : test_seq_read
    task automatic test_current_read();
        logic [7:0] d;
        ctrl.bus_start();
        send(ADDR_DEFAULT | 8'h01, 1'b1);
        ctrl.get_byte(1'b0, d);
        check(d, init_val(8'h13));
        ctrl.bus_stop();
        $display("test_current_read done");
    endtask : test_current_read
    task automatic test_select();
        ctrl.bus_start();
        send(ADDR_ALTERNATE, 1'b0);
        ctrl.bus_stop();
        @(posedge sys_clk);
        #1 addr_sel_lower = 1'b1;
        ctrl.bus_start();
        send(ADDR_ALTERNATE, 1'b1);
        send(8'h20, 1'b1);
        send(8'h5b, 1'b1);
        ctrl.bus_stop();
        check(regs[8'h20], 8'h5b);
        ctrl.bus_start();
        send(ADDR_DEFAULT, 1'b0);
        ctrl.bus_stop();
        check(regs[8'h13], init_val(8'h13));
        $display("test_select done");
    endtask : test_select
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    initial
    begin
        resetn = 1'b0;
        cfg_loaded = 1'b0;
        addr_sel_lower = 1'b0;
        wr_ready = 1'b0;
        errors = 0;
        n_compared = 0;
        n_commit = 0;
        cycles = 0;
        for (int i = 0; i < 256; i++)
        begin
            regs[i] = init_val(i);
            shadow[i] = 8'h00;
            pend[i] = 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge sys_clk);
        test_unloaded();
        test_write();
        test_seq_read();
        test_current_read();
        test_select();
        test_done();
    end
endmodule : cfg_i2c_target_bench
`default_nettype wire
